// *** rtl/dx_pkg.sv ***
// dx_pkg: opcodes, widths and reset values of the execute datapath
// What this block does
// (RULE_01) integer magnitude of source into any register
// (RULE_02) float magnitude of source into R0-R7
// (RULE_03) add with carry, two or three operands
// (RULE_04) integer add, no carry in
// (RULE_05) float add into extended register
// (RULE_06) bitwise and into destination
// (RULE_07) and with inverted second operand
// (RULE_08) arithmetic shift, negative count shifts right
// (RULE_09) logical shift, negative count shifts right
// (RULE_10) branch: register load or pc add; else pc+1
// (RULE_11) delayed relative branch adds three more
// (RULE_12) integer multiply into destination
// (RULE_13) float multiply into extended register
// (RULE_14) zero minus source minus carry
// (RULE_15) push: increment pointer, then store
// (RULE_16) pop: load at pointer, then decrement
// (RULE_17) float pop: load, then decrement pointer
// (RULE_18) interlocked load flags interlock, loads source
// (RULE_19) short immediate is 16-bit instruction field
// (RULE_20) direct operand read at 24-bit address
// (RULE_21) long immediate is 24-bit instruction field
// (RULE_22) relative branch adds signed 16-bit displacement
// (RULE_23) integer ops keep upper eight bits
// (RULE_24) carry sampled when operation starts
`default_nettype none
package dx_pkg;
   // ***************************************************
   // widths
   // ***************************************************
   localparam int DATA_W = 32;            // integer word
   localparam int EXT_W = 40;             // extended register
   localparam int ADDR_W = 24;            // memory address
   localparam int REG_AW = 5;             // register index
   localparam int REG_DEPTH = 28;         // register count
   localparam int SHORT_W = 16;           // short immediate
   localparam int OPC_W = 5;              // opcode field
   // ***************************************************
   // operation codes from the decoder
   // ***************************************************
   localparam logic [4:0] OPC_INT_MAG = 5'h00;   // int_magnitude_op
   localparam logic [4:0] OPC_FLT_MAG = 5'h01;   // float_magnitude_op
   localparam logic [4:0] OPC_ADC = 5'h02;       // add_with_carry_op
   localparam logic [4:0] OPC_ADD = 5'h03;       // int_add_op
   localparam logic [4:0] OPC_FADD = 5'h04;      // float_add_op
   localparam logic [4:0] OPC_AND = 5'h05;       // bitwise and
   localparam logic [4:0] OPC_ANDC = 5'h06;      // and_inverted_op
   localparam logic [4:0] OPC_SHA = 5'h07;       // arith_shift_op
   localparam logic [4:0] OPC_SHL = 5'h08;       // logic_shift_op
   localparam logic [4:0] OPC_BR = 5'h09;        // standard branch
   localparam logic [4:0] OPC_BRD = 5'h0a;       // cond_branch_delayed
   localparam logic [4:0] OPC_MUL = 5'h0b;       // int_multiply_op
   localparam logic [4:0] OPC_FMUL = 5'h0c;      // float_multiply_op
   localparam logic [4:0] OPC_NEGC = 5'h0d;      // negate_borrow_op
   localparam logic [4:0] OPC_PUSH = 5'h0e;      // integer push
   localparam logic [4:0] OPC_POP = 5'h0f;       // integer pop
   localparam logic [4:0] OPC_FPOP = 5'h10;      // stack_load_float_op
   localparam logic [4:0] OPC_LOCK = 5'h11;      // interlocked_int_load
   // ***************************************************
   // operand modes
   // ***************************************************
   localparam logic [1:0] MODE_REG = 2'h0;       // register
   localparam logic [1:0] MODE_SHORT = 2'h1;     // 16-bit immediate
   localparam logic [1:0] MODE_DIRECT = 2'h2;    // memory word
   localparam logic [1:0] MODE_LONG = 2'h3;      // 24-bit immediate
   // ***************************************************
   // values
   // ***************************************************
   localparam logic [7:0] FLT_ZERO_EXP = 8'h80;  // exponent of zero
   localparam logic [39:0] FLT_ZERO = 40'h8000000000;
   localparam logic [31:0] PC_STEP = 32'h00000001;   // fall-through
   localparam logic [31:0] DELAY_STEP = 32'h00000003; // delayed slot
   localparam logic [31:0] PC_RST = 32'h00000000;    // pc at reset
   localparam logic [31:0] SP_RST = 32'h00000000;    // sp at reset
endpackage
`default_nettype wire

// *** rtl/dx_regfile.sv ***
// dx_regfile: register file with two registered read ports
`default_nettype none
module dx_regfile #(
   parameter int WIDTH = dx_pkg::EXT_W,    // word width
   parameter int LOW_W = dx_pkg::DATA_W,   // integer part
   parameter int AW = dx_pkg::REG_AW,      // index width
   parameter int DEPTH = dx_pkg::REG_DEPTH // entries
)(
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic             we,
   input  wire logic             wr_hi,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr_a,
   input  wire logic [AW-1:0]    raddr_b,
   output logic      [WIDTH-1:0] rdata_a,
   output logic      [WIDTH-1:0] rdata_b
);
   logic [WIDTH-1:0] mem [DEPTH];          // storage
   // ***************************************************
   // write: upper bits kept unless wr_hi
   // ***************************************************
   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wr_hi ? wdata :
            {mem[waddr][WIDTH-1:LOW_W], wdata[LOW_W-1:0]}; // RULE_23
      end
   end
   // ***************************************************
   // registered reads
   // ***************************************************
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rdata_a <= '0;
         rdata_b <= '0;
      end
      else
      begin
         rdata_a <= mem[raddr_a];
         rdata_b <= mem[raddr_b];
      end
   end
endmodule
`default_nettype wire

// *** rtl/dx_exec_datapath.sv ***
// dx_exec_datapath: execute datapath with register file and stack
`default_nettype none
module dx_exec_datapath #(
   parameter int REG_DEPTH = dx_pkg::REG_DEPTH // register count
)(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        op_valid,
   input  wire logic [4:0]  op_code,
   input  wire logic        op_three,
   input  wire logic [1:0]  src_mode,
   input  wire logic [4:0]  dst_reg,
   input  wire logic [4:0]  src1_reg,
   input  wire logic [4:0]  src2_reg,
   input  wire logic [23:0] imm_word,
   input  wire logic        cond_true,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   output logic             busy,
   output logic             done,
   output logic             interlock,
   output logic             carry,
   output logic             mem_req,
   output logic             mem_we,
   output logic      [23:0] mem_addr,
   output logic      [31:0] mem_wdata,
   output logic      [31:0] pc,
   output logic      [31:0] sp,
   output logic      [39:0] result
);
   // **********
   // float helpers: exp[39:32], sign[31], frac[30:0]
   // **********
   // widen a memory or immediate word to extended form
   function automatic logic [39:0] to_flt(input logic [31:0] w);
      return {w, 8'h00};
   endfunction

   // sign-magnitude add with alignment and renormalise
   function automatic logic [39:0] f_add(input logic [39:0] x,
                                         input logic [39:0] y);
      logic [39:0] p;
      logic [39:0] q;
      logic [7:0]  d;
      logic [32:0] mp;
      logic [32:0] mq;
      logic [32:0] ms;
      logic [32:0] t;
      logic        sg;
      logic [5:0]  k;
      p = x;
      q = y;
      if (x[39:32] == dx_pkg::FLT_ZERO_EXP)
         return y;
      if (y[39:32] == dx_pkg::FLT_ZERO_EXP)
         return x;
      if ($signed(y[39:32]) > $signed(x[39:32]))
      begin
         p = y;
         q = x;
      end
      d = p[39:32] - q[39:32];
      mp = {2'b01, p[30:0]};
      mq = (d > 8'd32) ? 33'h0 : ({2'b01, q[30:0]} >> d);
      sg = p[31];
      // same signs add, else larger magnitude wins
      if (p[31] == q[31])
         ms = mp + mq;
      else if (mp >= mq)
         ms = mp - mq;
      else
      begin
         ms = mq - mp;
         sg = q[31];
      end
      if (ms == 33'h0)
         return dx_pkg::FLT_ZERO;
      k = 6'h00;
      for (int i = 0; i < 33; i++)
         if (ms[i])
            k = 6'(i);
      t = ms << (6'd32 - k);
      return {p[39:32] + {2'b00, k} - 8'd31, sg, t[31:1]};
   endfunction

   // sign-magnitude multiply, product in [1,4)
   function automatic logic [39:0] f_mul(input logic [39:0] x,
                                         input logic [39:0] y);
      logic [63:0] pr;
      logic [7:0]  e;
      logic        sg;
      if (x[39:32] == dx_pkg::FLT_ZERO_EXP ||
          y[39:32] == dx_pkg::FLT_ZERO_EXP)
         return dx_pkg::FLT_ZERO;
      pr = {1'b1, x[30:0]} * {1'b1, y[30:0]};
      e = x[39:32] + y[39:32];
      sg = x[31] ^ y[31];
      if (pr[63])
         return {e + 8'd1, sg, pr[62:32]};
      return {e, sg, pr[61:31]};
   endfunction

   // **********
   // state and latched operation
   // **********
   typedef enum logic [2:0] {
      ST_IDLE,                             // waits for op_valid
      ST_READ,                             // register read issued
      ST_OPER,                             // operands ready
      ST_MEM,                              // memory access
      ST_EXEC                              // result and write-back
   } dx_state_type;

   dx_state_type state;                    // sequencing state
   logic [4:0]  opc;                       // latched opcode
   logic        three;                     // three-operand form
   logic [1:0]  mode;                      // operand mode
   logic [4:0]  dst;                       // destination index
   logic [4:0]  s1;                        // first source index
   logic [4:0]  s2;                        // second source index
   logic [23:0] imm;                       // instruction field
   logic        cond;                      // branch condition
   logic        c_in;                      // carry at start
   logic [31:0] mem_buf;                   // word from memory

   // **********
   // decode
   // **********
   wire is_push = (opc == dx_pkg::OPC_PUSH);
   wire is_popi = (opc == dx_pkg::OPC_POP);
   wire is_fpop = (opc == dx_pkg::OPC_FPOP);
   wire is_pop = is_popi | is_fpop;
   wire is_br = (opc == dx_pkg::OPC_BR) | (opc == dx_pkg::OPC_BRD);
   wire is_float = (opc == dx_pkg::OPC_FLT_MAG) |
                   (opc == dx_pkg::OPC_FADD) |
                   (opc == dx_pkg::OPC_FMUL) | is_fpop;
   wire is_direct = (mode == dx_pkg::MODE_DIRECT) & ~is_br & ~is_push;
   wire writes_reg = ~is_br & ~is_push;

   // **********
   // register file
   // **********
   wire [39:0] rd_a;                       // dst or first source
   wire [39:0] rd_b;                       // second source
   wire [4:0]  ra = three ? s1 : dst;      // two-op reads dst
   wire [31:0] int_res;                    // integer result
   wire [39:0] flt_res;                    // float result
   wire        rf_we = (state == ST_EXEC) & writes_reg;
   wire [4:0]  rf_waddr = is_float ? {2'b00, dst[2:0]} : dst;
   wire [39:0] rf_wdata = is_float ? flt_res : {8'h00, int_res};

   dx_regfile #(
      .WIDTH (dx_pkg::EXT_W),
      .LOW_W (dx_pkg::DATA_W),
      .AW    (dx_pkg::REG_AW),
      .DEPTH (REG_DEPTH)
   ) u_regs (
      .clk     (clk),
      .nrst    (nrst),
      .we      (rf_we),
      .wr_hi   (is_float),
      .waddr   (rf_waddr),
      .wdata   (rf_wdata),
      .raddr_a (ra),
      .raddr_b (s2),
      .rdata_a (rd_a),
      .rdata_b (rd_b)
   );

   // **********
   // operand forming
   // **********
   wire [31:0] short_op = {{16{imm[15]}}, imm[15:0]}; // RULE_19
   wire [31:0] long_op = {8'h00, imm};                 // RULE_21
   wire [31:0] b32 = (mode == dx_pkg::MODE_REG)   ? rd_b[31:0] :
                     (mode == dx_pkg::MODE_SHORT) ? short_op :
                     (mode == dx_pkg::MODE_LONG)  ? long_op :
                     mem_buf;                          // RULE_20
   wire [39:0] b40 = (mode == dx_pkg::MODE_REG) ? rd_b : to_flt(b32);
   wire [31:0] a32 = rd_a[31:0];

   // **********
   // integer unit
   // **********
   wire [32:0] sum_c = {1'b0, a32} + {1'b0, b32} + {32'h0, c_in};
   wire [32:0] sum_i = {1'b0, a32} + {1'b0, b32};
   wire [32:0] neg_b = 33'h0 - {1'b0, b32} - {32'h0, c_in};
   wire [31:0] mag = b32[31] ? 32'h0 - b32 : b32;
   wire        cnt_neg = b32[6];           // signed 7-bit count
   wire [6:0]  cnt_mag = cnt_neg ? ~b32[6:0] + 7'h01 : b32[6:0];
   wire [31:0] shl = a32 << cnt_mag;
   wire [31:0] arsh_r = $unsigned($signed(a32) >>> cnt_mag);
   wire [31:0] lgsh_r = a32 >> cnt_mag;
   wire [31:0] arsh = cnt_neg ? arsh_r : shl;
   wire [31:0] lgsh = cnt_neg ? lgsh_r : shl;
   wire signed [47:0] prod = $signed(a32[23:0]) * $signed(b32[23:0]);

   // integer result select
   assign int_res =
      (opc == dx_pkg::OPC_INT_MAG) ? mag :          // RULE_01
      (opc == dx_pkg::OPC_ADC)     ? sum_c[31:0] :  // RULE_03
      (opc == dx_pkg::OPC_ADD)     ? sum_i[31:0] :  // RULE_04
      (opc == dx_pkg::OPC_AND)     ? a32 & b32 :    // RULE_06
      (opc == dx_pkg::OPC_ANDC)    ? a32 & ~b32 :   // RULE_07
      (opc == dx_pkg::OPC_SHA)     ? arsh :         // RULE_08
      (opc == dx_pkg::OPC_SHL)     ? lgsh :         // RULE_09
      (opc == dx_pkg::OPC_MUL)     ? prod[31:0] :   // RULE_12
      (opc == dx_pkg::OPC_NEGC)    ? neg_b[31:0] :  // RULE_14
      is_popi                      ? mem_buf :      // RULE_16
      b32;                                          // RULE_18

   // **********
   // float unit
   // **********
   assign flt_res =
      (opc == dx_pkg::OPC_FLT_MAG) ?
         {b40[39:32], 1'b0, b40[30:0]} :            // RULE_02
      (opc == dx_pkg::OPC_FADD) ? f_add(rd_a, b40) : // RULE_05
      (opc == dx_pkg::OPC_FMUL) ? f_mul(rd_a, b40) : // RULE_13
      to_flt(mem_buf);                              // RULE_17

   // **********
   // branch target
   // **********
   wire [31:0] br_extra = (opc == dx_pkg::OPC_BRD) ?
                          dx_pkg::DELAY_STEP : 32'h0;
   wire [31:0] rel_tgt = pc + short_op + br_extra;  // RULE_22 RULE_11
   wire [31:0] br_tgt = (mode == dx_pkg::MODE_REG) ? rd_b[31:0] : rel_tgt;
   wire [31:0] next_pc = cond ? br_tgt : pc + dx_pkg::PC_STEP; // RULE_10
   wire [31:0] sp_inc = sp + 32'h1;
   wire [31:0] sp_dec = sp - 32'h1;

   // **********
   // sequencing and operation latch
   // **********
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= ST_IDLE;
         opc <= dx_pkg::OPC_INT_MAG;
         three <= 1'b0;
         mode <= dx_pkg::MODE_REG;
         dst <= 5'h00;
         s1 <= 5'h00;
         s2 <= 5'h00;
         imm <= 24'h000000;
         cond <= 1'b0;
         c_in <= 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (op_valid)
               begin
                  opc <= op_code;
                  three <= op_three;
                  mode <= src_mode;
                  dst <= dst_reg;
                  s1 <= src1_reg;
                  s2 <= src2_reg;
                  imm <= imm_word;
                  cond <= cond_true;
                  c_in <= carry;               // RULE_24
                  state <= ST_READ;
               end
            end
            ST_READ:
               state <= ST_OPER;
            // memory needed for direct operand or stack
            ST_OPER:
               state <= (is_push | is_pop | is_direct) ? ST_MEM : ST_EXEC;
            ST_MEM:
               if (mem_ack)
                  state <= ST_EXEC;
            ST_EXEC:
               state <= ST_IDLE;
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // **********
   // memory side: push writes, pop and direct read
   // **********
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= 24'h000000;
         mem_wdata <= 32'h00000000;
         mem_buf <= 32'h00000000;
      end
      else if (state == ST_OPER)
      begin
         mem_req <= is_push | is_pop | is_direct;
         mem_we <= is_push;
         mem_wdata <= rd_b[31:0];
         // push stores at the incremented pointer
         if (is_push)
            mem_addr <= sp_inc[23:0];          // RULE_15
         else if (is_pop)
            mem_addr <= sp[23:0];              // RULE_16 RULE_17
         else
            mem_addr <= imm;                   // RULE_20
      end
      else if (state == ST_MEM && mem_ack)
      begin
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_buf <= mem_rdata;
      end
   end

   // **********
   // stack pointer, pc, carry
   // **********
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         sp <= dx_pkg::SP_RST;
      else if (state == ST_OPER && is_push)
         sp <= sp_inc;                         // RULE_15
      else if (state == ST_EXEC && is_pop)
         sp <= sp_dec;                         // RULE_16 RULE_17
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         pc <= dx_pkg::PC_RST;
      else if (state == ST_EXEC && is_br)
         pc <= next_pc;                        // RULE_10
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         carry <= 1'b0;
      else if (state == ST_EXEC)
      begin
         if (opc == dx_pkg::OPC_ADC)
            carry <= sum_c[32];                // RULE_03
         else if (opc == dx_pkg::OPC_ADD)
            carry <= sum_i[32];
         else if (opc == dx_pkg::OPC_NEGC)
            carry <= neg_b[32];                // RULE_14
      end
   end

   // **********
   // status outputs and result
   // **********
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         busy <= 1'b0;
         done <= 1'b0;
         interlock <= 1'b0;
         result <= 40'h0000000000;
      end
      else
      begin
         done <= (state == ST_EXEC);
         busy <= (state == ST_IDLE) ? op_valid : (state != ST_EXEC);
         // interlock is high from the cycle after operands through write-back
         if (state == ST_OPER)
            interlock <= (opc == dx_pkg::OPC_LOCK); // RULE_18
         else if (state == ST_EXEC)
            interlock <= 1'b0;
         if (rf_we)
            result <= rf_wdata;
      end
   end
endmodule
`default_nettype wire

// *** tb/dx_exec_datapath_checker.sv ***
// dx_exec_datapath_checker: timing relations at the datapath ports
`default_nettype none
module dx_exec_datapath_checker #(
   parameter int REG_DEPTH = dx_pkg::REG_DEPTH  // register count
)(
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        op_valid,
   input wire logic [4:0]  op_code,
   input wire logic [1:0]  src_mode,
   input wire logic [23:0] imm_word,
   input wire logic        cond_true,
   input wire logic        mem_ack,
   input wire logic        busy,
   input wire logic        done,
   input wire logic        interlock,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [23:0] mem_addr,
   input wire logic [31:0] pc,
   input wire logic [31:0] sp
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // sign-extended displacement and accepted request
   wire logic [31:0] disp = {{16{imm_word[15]}}, imm_word[15:0]};
   wire logic        take = op_valid && !busy;
   add_done_a: assert property (take && op_code == dx_pkg::OPC_ADD &&
      src_mode != dx_pkg::MODE_DIRECT |-> ##4 done && !busy)
      else $error("add completion late");
   push_sp_a: assert property (take && op_code == dx_pkg::OPC_PUSH |->
      ##3 mem_req && mem_we && sp == $past(sp, 3) + 1 &&
      mem_addr == sp[23:0]) else $error("push pointer wrong");
   pop_addr_a: assert property (take && op_code == dx_pkg::OPC_POP |->
      ##3 mem_req && !mem_we && mem_addr == sp[23:0])
      else $error("pop address wrong");
   mem_hold_a: assert property (mem_req && !mem_ack |=>
      mem_req && $stable(mem_addr) && $stable(mem_we))
      else $error("memory request dropped");
   mem_done_a: assert property (mem_req && mem_ack |->
      ##1 !mem_req ##1 done) else $error("memory finish wrong");
   br_false_a: assert property (take && op_code == dx_pkg::OPC_BR &&
      !cond_true |-> ##4 done && pc == $past(pc, 4) + 1)
      else $error("untaken branch wrong");
   brd_rel_a: assert property (take && op_code == dx_pkg::OPC_BRD &&
      cond_true && src_mode != dx_pkg::MODE_REG |->
      ##4 pc == $past(pc, 4) + $past(disp, 4) + 3)
      else $error("delayed branch target wrong");
   lock_on_a: assert property (take && op_code == dx_pkg::OPC_LOCK |->
      ##[3:5] interlock) else $error("interlock missing");
endmodule
bind dx_exec_datapath dx_exec_datapath_checker #(.REG_DEPTH(REG_DEPTH))
   i_chk (.clk, .nrst, .op_valid, .op_code, .src_mode, .imm_word,
   .cond_true, .mem_ack, .busy, .done, .interlock, .mem_req, .mem_we,
   .mem_addr, .pc, .sp);
`default_nettype wire

// *** tb/dx_mem_model.sv ***
// dx_mem_model: data memory answering the datapath's word requests
`default_nettype none
module dx_mem_model (
   input  wire logic        clk,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [23:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   input  wire logic [1:0]  lat,
   output logic             mem_ack,
   output logic      [31:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] mem [256];  // word store on low address bits
   logic [1:0]  cnt;        // wait cycles so far
   logic        gap;        // one quiet cycle after each answer
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 32'h00a50000 | 32'(i);
      {mem_ack, mem_rdata, cnt, gap} = '0;
   end
   // answer after lat waits; data scrambles outside the answer
   always @(posedge clk)
   begin
      mem_rdata <= ~mem_rdata;
      mem_ack <= 1'b0;
      gap <= mem_ack;
      if (mem_req && !mem_ack && !gap && cnt >= lat)
      begin
         mem_ack <= 1'b1;
         mem_rdata <= mem[mem_addr[7:0]];
         if (mem_we)
            mem[mem_addr[7:0]] <= mem_wdata;
      end
      cnt <= (mem_req && !mem_ack && cnt < lat) ? cnt + 2'h1 : 2'h0;
   end
endmodule
`default_nettype wire

// *** tb/dx_exec_datapath_tb.sv ***
// dx_exec_datapath_tb: random and directed checks of the datapath
`default_nettype none
module dx_exec_datapath_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, nrst, op_valid, op_three, cond_true, cy;
   logic [4:0]  op_code, dst_reg, src1_reg, src2_reg, c;
   logic [1:0]  src_mode, lat;
   logic [23:0] imm_word, mem_addr;
   logic        mem_ack, busy, done, interlock, carry, mem_req, mem_we;
   logic [31:0] mem_rdata, mem_wdata, pc, sp, pcm, spm;
   logic [39:0] result;
   logic [31:0] rm [8];     // integer model of r0-r7
   int          miscompares, checked, cycles, seed;
   localparam logic [4:0] ops [9] = '{dx_pkg::OPC_ADD, dx_pkg::OPC_ADC,
      dx_pkg::OPC_AND, dx_pkg::OPC_ANDC, dx_pkg::OPC_MUL, dx_pkg::OPC_NEGC,
      dx_pkg::OPC_INT_MAG, dx_pkg::OPC_SHA, dx_pkg::OPC_SHL};
   dx_exec_datapath i_dut (.clk, .nrst, .op_valid,
      .op_code, .op_three, .src_mode, .dst_reg, .src1_reg, .src2_reg,
      .imm_word, .cond_true, .mem_ack, .mem_rdata, .busy, .done,
      .interlock, .carry, .mem_req, .mem_we, .mem_addr, .mem_wdata, .pc,
      .sp, .result);
   dx_mem_model i_mem (.clk, .mem_req, .mem_we, .mem_addr, .mem_wdata,
      .lat, .mem_ack, .mem_rdata);
   always #50 clk = ~clk;
   // hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         conclude();
      end
   end
   task automatic conclude();
      if (miscompares == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp(logic [39:0] got, logic [39:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one request, then wait for its done pulse
   task automatic op(logic [4:0] o, logic t, logic [1:0] m,
                     logic [4:0] d, s1, s2, logic [23:0] i, logic k);
      int n;
      {op_code, op_three, src_mode, dst_reg} = {o, t, m, d};
      {src1_reg, src2_reg, imm_word, cond_true} = {s1, s2, i, k};
      lat = 2'($random(seed));
      op_valid = 1'b1;
      @(posedge clk);
      #1 op_valid = 1'b0;
      n = 0;
      do
      begin
         @(posedge clk);
         #1 n++;
      end while (done !== 1'b1 && n < 40);
      cmp({39'h0, done}, 40'h1);
   endtask
   function automatic logic [32:0] calc(logic [4:0] o, logic [31:0] a, b,
                                        logic ci);
      logic signed [47:0] p;
      logic signed [6:0]  n;
      p = $signed(a[23:0]) * $signed(b[23:0]);
      n = b[6:0];
      case (o)
         dx_pkg::OPC_ADC: calc = a + b + ci;
         dx_pkg::OPC_AND: calc = {ci, a & b};
         dx_pkg::OPC_ANDC: calc = {ci, a & ~b};
         dx_pkg::OPC_MUL: calc = {ci, p[31:0]};
         dx_pkg::OPC_NEGC: calc = 33'h0 - b - ci;
         dx_pkg::OPC_INT_MAG: calc = {ci, b[31] ? -b : b};
         dx_pkg::OPC_SHA:
            calc = {ci, n < 0 ? 32'($signed(a) >>> -n) : a << n};
         dx_pkg::OPC_SHL: calc = {ci, n < 0 ? a >> -n : a << n};
         default: calc = a + b;
      endcase
   endfunction
   task automatic alu(logic [4:0] o, logic t, logic [1:0] m,
                      logic [2:0] d, s1, s2, logic [23:0] i);
      logic [32:0] r;
      r = calc(o, t ? rm[s1] : rm[d], m ? {8'h0, i} : rm[s2], cy);
      op(o, t, m, 5'(d), 5'(s1), 5'(s2), i, 1'b0);
      cmp(result, {8'h00, r[31:0]});
      rm[d] = r[31:0];
      if (o inside {dx_pkg::OPC_ADD, dx_pkg::OPC_ADC, dx_pkg::OPC_NEGC})
         cy = r[32];
   endtask
   task automatic br(logic [4:0] o, logic [1:0] m, logic k, logic [15:0] i);
      op(o, 1'b0, m, 5'h0, 5'h0, 5'h2, {8'h00, i}, k);
      pcm = !k ? pcm + 1 : m == dx_pkg::MODE_REG ? rm[2] :
         pcm + {{16{i[15]}}, i} + (o == dx_pkg::OPC_BRD ? 32'h3 : 32'h0);
      cmp(pc, pcm);
   endtask
   task automatic stk(logic [4:0] o, logic [4:0] s, logic [39:0] e);
      op(o, 1'b0, dx_pkg::MODE_REG, 5'h3, 5'h0, s, 24'h0, 1'b0);
      spm = o == dx_pkg::OPC_PUSH ? spm + 1 : spm - 1;
      cmp(sp, spm);
      if (o != dx_pkg::OPC_PUSH)
         cmp(result, e);
   endtask
   initial
   begin
      {clk, nrst, op_valid, op_three, cond_true, op_code, dst_reg} = '0;
      {src1_reg, src2_reg, src_mode, imm_word, lat, cy, pcm, spm} = '0;
      {miscompares, checked, cycles} = '0;
      seed = 32'h5e35;
      repeat (10) @(posedge clk);
      #1 nrst = 1'b1;
      for (int k = 0; k < 8; k++)
         alu(dx_pkg::OPC_INT_MAG, 1'b1, dx_pkg::MODE_LONG, 3'(k), 3'h0,
            3'h0, 24'($random(seed)) & 24'h007fff);
      for (int k = 0; k < 60; k++)
      begin
         c = ops[$unsigned($random(seed)) % 9];
         alu(c, 1'($random(seed)), (c == dx_pkg::OPC_SHA ||
            c == dx_pkg::OPC_SHL) ? dx_pkg::MODE_SHORT : dx_pkg::MODE_REG,
            3'($random(seed)), 3'($random(seed)), 3'($random(seed)),
            {17'h0, 7'($random(seed) % 32)});
      end
      stk(dx_pkg::OPC_PUSH, 5'h1, 40'h0);
      stk(dx_pkg::OPC_POP, 5'h0, {8'h00, rm[1]});
      stk(dx_pkg::OPC_PUSH, 5'h1, 40'h0);
      stk(dx_pkg::OPC_FPOP, 5'h0, {rm[1], 8'h00});
      stk(dx_pkg::OPC_POP, 5'h0, 40'h00a50000);
      op(dx_pkg::OPC_INT_MAG, 1'b1, dx_pkg::MODE_DIRECT, 5'h5, 5'h0, 5'h0,
         24'h400005, 1'b0);
      cmp(result, 40'h00a50005);
      op(dx_pkg::OPC_LOCK, 1'b1, dx_pkg::MODE_DIRECT, 5'h6, 5'h0, 5'h0,
         24'h000107, 1'b0);
      cmp(result, 40'h00a50007);
      br(dx_pkg::OPC_BR, dx_pkg::MODE_SHORT, 1'b0, 16'h1234);
      br(dx_pkg::OPC_BR, dx_pkg::MODE_REG, 1'b1, 16'h0);
      br(dx_pkg::OPC_BR, dx_pkg::MODE_SHORT, 1'b1, 16'hfff0);
      br(dx_pkg::OPC_BRD, dx_pkg::MODE_SHORT, 1'b1, 16'h0010);
      br(dx_pkg::OPC_BRD, dx_pkg::MODE_REG, 1'b1, 16'h0);
      br(dx_pkg::OPC_BRD, dx_pkg::MODE_SHORT, 1'b0, 16'h8000);
      conclude();
   end
endmodule
`default_nettype wire
